// File: design/ets_sequencer.sv
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Free run uses normal shutter; both trigger modes allow normal or early
// - Shutter normal, early, disabled open, disabled closed; disabled stays put
// - Early open opens shutter once ready for a trigger edge
// - Free run opens after readout for exposure time, ignores trigger
// - One sync output carries shutter or active-low readout, selectable
// - Trigger modes react only to the chosen edge, rising or falling
// - Normal trigger mode: edge, expose with shutter open, close, read
// - Early trigger mode: expose after edge, close, read, reopen after
// - Trigger still active at readout end counts as a new trigger
// - One standard clean pass after enable in every mode
// - Continuous cleaning repeats row shifts until the trigger edge
// - Edge during a row shift waits until that shift ends
// - Early open keeps shutter open through continuous cleaning and exposure
module ets_sequencer (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_EXT_TRIG,
	output logic O_SHUTTER,
	output logic O_SYNC,
	output logic O_READOUT_N,
	output logic O_CLEANING,
	output logic O_ROW_SHIFT
);

	typedef struct packed {
		logic en;
		logic [1:0] tmode;
		logic [1:0] shut;
		logic rise;
		logic sync_sel;
		logic [31:0] exposure;
		logic [15:0] rows;
		logic [15:0] row_time;
		ets_pkg::ets_state_type st;
		logic [31:0] cnt;
		logic [15:0] line;
		logic pend;
		logic [15:0] frames;
		logic [31:0] prdata;
		logic shutter;
		logic reading;
		logic sync;
		logic cleaning;
		logic shift;
	} ets_seq_type;

	localparam ets_seq_type SEQ_RST = '{
		en: 1'b0,
		tmode: ets_pkg::TM_FREE,
		shut: ets_pkg::SH_NORMAL,
		rise: 1'b0,
		sync_sel: 1'b0,
		exposure: ets_pkg::EXPOSURE_RST,
		rows: ets_pkg::ROWS_RST,
		row_time: ets_pkg::ROW_TIME_RST,
		st: ets_pkg::ETS_IDLE,
		cnt: 32'h0,
		line: 16'h0,
		pend: 1'b0,
		frames: 16'h0,
		prdata: 32'h0,
		shutter: 1'b0,
		reading: 1'b0,
		sync: 1'b0,
		cleaning: 1'b0,
		shift: 1'b0
	};

	ets_seq_type r_reg;
	ets_seq_type r_next;

	logic trig_active;
	logic trig_edge;
	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic row_done;
	logic last_row;
	logic trig_mode;
	logic trig_seen;
	logic early;
	logic open_now;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////
	// Trigger pin to clock domain
	ets_trig_sync u_trig (
		.i_clk(I_REF_CLK),
		.i_resetn(I_RESETN),
		.i_trig(I_EXT_TRIG),
		.i_rise(r_reg.rise),
		.o_active(trig_active),
		.o_edge(trig_edge)
	);

	////////////////////////////////////////////////////////////////////
	// Bus decode, single-cycle access phase
	// Ready never drops, so no wait states are inserted
	// Unmapped offsets answer with an error and read as zero
	assign addr_ok = (I_PADDR == ets_pkg::OFS_CTRL)
		| (I_PADDR == ets_pkg::OFS_EXPOSURE)
		| (I_PADDR == ets_pkg::OFS_ROWS)
		| (I_PADDR == ets_pkg::OFS_ROW_TIME)
		| (I_PADDR == ets_pkg::OFS_STATUS);
	assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;

	// Status word gathers sequencer state
	always_comb begin
		status_word = 32'h0;
		status_word[ets_pkg::STAT_STATE +: 3] = r_reg.st;
		status_word[ets_pkg::STAT_PEND] = r_reg.pend;
		status_word[ets_pkg::STAT_READ] = r_reg.reading;
		status_word[ets_pkg::STAT_SHUT] = r_reg.shutter;
		status_word[ets_pkg::STAT_FRAMES +: 16] = r_reg.frames;
	end

	////////////////////////////////////////////////////////////////////
	// Helper terms for the sequencer
	assign row_done = (r_reg.cnt == 32'h0);
	assign last_row = row_done & (r_reg.line <= 16'h1);
	// A held edge counts as seen in any state that listens
	// Free run never listens to the trigger
	assign trig_mode = (r_reg.tmode != ets_pkg::TM_FREE);
	assign trig_seen = r_reg.pend | (trig_mode & trig_edge);
	// Early open only exists in the trigger modes
	assign early = (r_reg.shut == ets_pkg::SH_EARLY_OPEN)
		& trig_mode;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.shift = 1'b0;
		open_now = 1'b0;

		// Register writes
		if (wr_en) begin
			unique case (I_PADDR)
				ets_pkg::OFS_CTRL: begin
					r_next.en = I_PWDATA[ets_pkg::CTRL_EN];
					r_next.tmode = I_PWDATA[ets_pkg::CTRL_TMODE +: 2];
					r_next.shut = I_PWDATA[ets_pkg::CTRL_SHUT +: 2];
					r_next.rise = I_PWDATA[ets_pkg::CTRL_RISE];
					r_next.sync_sel = I_PWDATA[ets_pkg::CTRL_SYNC_SEL];
				end
				ets_pkg::OFS_EXPOSURE: begin
					r_next.exposure = I_PWDATA;
				end
				ets_pkg::OFS_ROWS: begin
					r_next.rows = I_PWDATA[15:0];
				end
				ets_pkg::OFS_ROW_TIME: begin
					r_next.row_time = I_PWDATA[15:0];
				end
				default: begin
				end
			endcase
		end

		// Read data captured in the setup cycle
		// Latching at setup gives the access cycle a settled word
		// Status is sampled one cycle before the master takes it
		if (rd_setup) begin
			unique case (I_PADDR)
				ets_pkg::OFS_CTRL: begin
					r_next.prdata = {25'h0, r_reg.sync_sel, r_reg.rise,
						r_reg.shut, r_reg.tmode, r_reg.en};
				end
				ets_pkg::OFS_EXPOSURE: begin
					r_next.prdata = r_reg.exposure;
				end
				ets_pkg::OFS_ROWS: begin
					r_next.prdata = {16'h0, r_reg.rows};
				end
				ets_pkg::OFS_ROW_TIME: begin
					r_next.prdata = {16'h0, r_reg.row_time};
				end
				ets_pkg::OFS_STATUS: begin
					r_next.prdata = status_word;
				end
				default: begin
					r_next.prdata = 32'h0;
				end
			endcase
		end

		// Row shift timer shared by both clean kinds and readout
		// A row takes row_time plus one cycles
		// The shift pulse is registered and shows the cycle after a row
		// ends, so the last row's pulse falls in the state that follows
		if (r_reg.st == ets_pkg::ETS_CLEAN
			|| r_reg.st == ets_pkg::ETS_CCLEAN
			|| r_reg.st == ets_pkg::ETS_READ) begin
			if (row_done) begin
				r_next.shift = 1'b1;
				r_next.cnt = {16'h0, r_reg.row_time};
				r_next.line = r_reg.line - 16'h1;
			end else begin
				r_next.cnt = r_reg.cnt - 32'h1;
			end
		end

		// Sequencer
		unique case (r_reg.st)
			ets_pkg::ETS_IDLE: begin
				r_next.pend = 1'b0;
				if (r_reg.en) begin
					r_next.st = ets_pkg::ETS_CLEAN;
					r_next.cnt = {16'h0, r_reg.row_time};
					r_next.line = r_reg.rows;
				end
			end
			ets_pkg::ETS_CLEAN: begin
				// Edges before the pass ends are dropped
				r_next.pend = 1'b0;
				if (last_row) begin
					r_next.st = ets_pkg::ETS_ARM;
					if (r_reg.tmode == ets_pkg::TM_FREE) begin
						r_next.st = ets_pkg::ETS_EXPOSE;
						r_next.cnt = r_reg.exposure;
					end else if (r_reg.tmode == ets_pkg::TM_EXT_CLEAN) begin
						r_next.st = ets_pkg::ETS_CCLEAN;
					end
				end
			end
			ets_pkg::ETS_ARM: begin
				if (trig_seen) begin
					r_next.st = ets_pkg::ETS_EXPOSE;
					r_next.cnt = r_reg.exposure;
					r_next.pend = 1'b0;
				end
			end
			ets_pkg::ETS_CCLEAN: begin
				// Edge mid-shift is held until the shift ends
				// Row count is reloaded so cleaning never runs out
				r_next.pend = trig_seen;
				r_next.line = r_reg.rows;
				if (row_done && trig_seen) begin
					r_next.st = ets_pkg::ETS_EXPOSE;
					r_next.cnt = r_reg.exposure;
					r_next.pend = 1'b0;
				end
			end
			ets_pkg::ETS_EXPOSE: begin
				r_next.pend = 1'b0;
				// Exposure counts down, zero or one gives one cycle
				if (r_reg.cnt <= 32'h1) begin
					r_next.st = ets_pkg::ETS_READ;
					r_next.cnt = {16'h0, r_reg.row_time};
					r_next.line = r_reg.rows;
					r_next.frames = r_reg.frames + 16'h1;
				end else begin
					r_next.cnt = r_reg.cnt - 32'h1;
				end
			end
			ets_pkg::ETS_READ: begin
				r_next.pend = 1'b0;
				if (last_row) begin
					// Trigger still active reads as a fresh edge
					r_next.pend = trig_mode & trig_active;
					r_next.cnt = {16'h0, r_reg.row_time};
					r_next.line = r_reg.rows;
					unique case (r_reg.tmode)
						ets_pkg::TM_EXT: begin
							r_next.st = ets_pkg::ETS_ARM;
						end
						ets_pkg::TM_EXT_CLEAN: begin
							r_next.st = ets_pkg::ETS_CCLEAN;
						end
						default: begin
							r_next.st = ets_pkg::ETS_EXPOSE;
							r_next.cnt = r_reg.exposure;
						end
					endcase
				end
			end
			default: begin
				r_next.st = ets_pkg::ETS_IDLE;
			end
		endcase

		// Disable returns to idle at once
		// A frame cut by a disable is dropped, the count is kept
		if (!r_reg.en) begin
			r_next.st = ets_pkg::ETS_IDLE;
			r_next.shift = 1'b0;
		end

		// Shutter follows the next state
		// Deriving it from the next state keeps it aligned with status
		// Disabled settings override every state, idle included
		open_now = (r_next.st == ets_pkg::ETS_EXPOSE)
			| (early & (r_next.st == ets_pkg::ETS_ARM
			|| r_next.st == ets_pkg::ETS_CCLEAN));
		unique case (r_reg.shut)
			ets_pkg::SH_DIS_OPEN: r_next.shutter = 1'b1;
			ets_pkg::SH_DIS_CLOSED: r_next.shutter = 1'b0;
			default: r_next.shutter = open_now;
		endcase
		r_next.reading = (r_next.st == ets_pkg::ETS_READ);
		r_next.cleaning = (r_next.st == ets_pkg::ETS_CLEAN)
			| (r_next.st == ets_pkg::ETS_CCLEAN);
		// Sync output source
		r_next.sync = r_reg.sync_sel ? ~r_next.reading
			: r_next.shutter;
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			r_reg <= SEQ_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs from flops
	// Every output assigned here is a flop, so no glitch reaches these pins
	assign O_PRDATA = r_reg.prdata;
	assign O_SHUTTER = r_reg.shutter;
	assign O_SYNC = r_reg.sync;
	assign O_READOUT_N = ~r_reg.reading;
	assign O_CLEANING = r_reg.cleaning;
	assign O_ROW_SHIFT = r_reg.shift;

endmodule : ets_sequencer

// File: design/ets_pkg.sv
////////////////////////////////////////////////////////////////////////
// Shared constants of the exposure trigger sequencer
package ets_pkg;

	// Sequencer states, Gray codes along clean, arm, expose, read
	typedef enum logic [2:0] {
		ETS_IDLE = 3'h0,
		ETS_CLEAN = 3'h1,
		ETS_ARM = 3'h3,
		ETS_EXPOSE = 3'h2,
		ETS_READ = 3'h6,
		ETS_CCLEAN = 3'h7
	} ets_state_type;

	// Timing modes
	localparam logic [1:0] TM_FREE = 2'h0;
	localparam logic [1:0] TM_EXT = 2'h1;
	localparam logic [1:0] TM_EXT_CLEAN = 2'h2;

	// Shutter settings
	localparam logic [1:0] SH_NORMAL = 2'h0;
	localparam logic [1:0] SH_EARLY_OPEN = 2'h1;
	localparam logic [1:0] SH_DIS_OPEN = 2'h2;
	localparam logic [1:0] SH_DIS_CLOSED = 2'h3;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EXPOSURE = 8'h04;
	localparam logic [7:0] OFS_ROWS = 8'h08;
	localparam logic [7:0] OFS_ROW_TIME = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Control field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_TMODE = 1;
	localparam int CTRL_SHUT = 3;
	localparam int CTRL_RISE = 5;
	localparam int CTRL_SYNC_SEL = 6;

	// Status field positions
	localparam int STAT_STATE = 0;
	localparam int STAT_PEND = 3;
	localparam int STAT_READ = 4;
	localparam int STAT_SHUT = 5;
	localparam int STAT_FRAMES = 16;

	// Row shift time and clock period
	localparam int CLK_PERIOD_NS = 5;
	localparam int ROW_TIME_NS = 1000;
	localparam int ROW_TIME_CYC = ROW_TIME_NS / CLK_PERIOD_NS;

	// Values after reset
	localparam logic [31:0] EXPOSURE_RST = 32'h0000_03e8;
	localparam logic [15:0] ROWS_RST = 16'h0200;
	localparam logic [15:0] ROW_TIME_RST = 16'(ROW_TIME_CYC);

endpackage : ets_pkg

// File: design/ets_trig_sync.sv
////////////////////////////////////////////////////////////////////////
// Trigger pin synchroniser and selectable edge detector
module ets_trig_sync (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_trig,
	input wire logic i_rise,
	output logic o_active,
	output logic o_edge
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ets_sync_type;

	ets_sync_type r_reg;
	ets_sync_type r_next;

	// Shift chain, first stage only feeds the second
	always_comb begin
		r_next = r_reg;
		r_next.s1 = i_trig;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Active level and chosen edge
	assign o_active = i_rise ? r_reg.s2 : ~r_reg.s2;
	assign o_edge = i_rise ? (r_reg.s2 & ~r_reg.s3)
		: (~r_reg.s2 & r_reg.s3);

endmodule : ets_trig_sync

// File: sim/ets_seq_sva.sv
////////////////////////////////////////////////////////////////////////
// Port level checks of the sequencer
module ets_seq_sva (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic I_EXT_TRIG,
	input wire logic O_SHUTTER,
	input wire logic O_SYNC,
	input wire logic O_READOUT_N,
	input wire logic O_CLEANING,
	input wire logic O_ROW_SHIFT
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);

	// Bus side
	a_ready_high: assert property (O_PREADY)
		else $error("ready low");
	a_err_access: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
		else $error("error outside access phase");
	a_rdata_hold: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE)
		|=> $stable(O_PRDATA)) else $error("read data moved");

	// Sequencer side
	a_sync_source: assert property (
		O_SYNC == O_SHUTTER || O_SYNC == O_READOUT_N
		|| O_SYNC == $past(O_SHUTTER) || O_SYNC == $past(O_READOUT_N))
		else $error("sync follows neither source");
	a_shift_single: assert property (O_ROW_SHIFT |=> !O_ROW_SHIFT)
		else $error("row shift longer than one cycle");
	a_shift_cause: assert property (
		O_ROW_SHIFT |-> O_CLEANING || !O_READOUT_N
		|| $past(O_CLEANING) || !$past(O_READOUT_N))
		else $error("row shift while neither cleaning nor reading");
	a_clean_read: assert property (!(O_CLEANING && !O_READOUT_N))
		else $error("cleaning during readout");
	a_reset_outs: assert property ($rose(I_RESETN) |-> !O_SHUTTER
		&& O_READOUT_N && !O_CLEANING && !O_ROW_SHIFT && !O_SYNC)
		else $error("outputs not at rest after reset");
	a_read_span: assert property (
		$fell(O_READOUT_N) |=> !O_READOUT_N [*3])
		else $error("readout too short");
	a_read_ends: assert property (
		$fell(O_READOUT_N) |-> ##[1:1000] O_READOUT_N)
		else $error("readout never ends");
endmodule : ets_seq_sva

// Attach to every sequencer
bind ets_sequencer ets_seq_sva u_sva (
	.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .I_EXT_TRIG(I_EXT_TRIG), .O_SHUTTER(O_SHUTTER),
	.O_SYNC(O_SYNC), .O_READOUT_N(O_READOUT_N), .O_CLEANING(O_CLEANING),
	.O_ROW_SHIFT(O_ROW_SHIFT)
);

// File: sim/ets_trig_src.sv
////////////////////////////////////////////////////////////////////////
// Experiment side: drives the trigger pin, level held between calls
module ets_trig_src (
	input wire logic i_clk,
	output logic o_trig
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_trig = 1'b0;
	// Waits some edges, then moves the pin; callers drop the active
	// level before readout ends unless a rerun is wanted
	task automatic drive(input logic v, input int dly);
		repeat (dly) @(posedge i_clk);
		o_trig <= v;
	endtask : drive
endmodule : ets_trig_src

// File: sim/ets_sequencer_tb_top.sv
////////////////////////////////////////////////////////////////////////
// Self-checking bench of the sequencer
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 4000) begin \
	@(posedge clk) #1; k++; end if (!(c)) begin n_mismatch++; summarize(); end end
module ets_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd, r;
	logic rdy, err, e, trig, shut, sync, rdn, cln, shf;
	int n_mismatch = 0;
	int n_compared = 0;
	int n, k;

	// 200 MHz reference
	always #2.5 clk = ~clk;

	ets_sequencer dut (
		.I_REF_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd),
		.O_PREADY(rdy), .O_PSLVERR(err), .I_EXT_TRIG(trig),
		.O_SHUTTER(shut), .O_SYNC(sync), .O_READOUT_N(rdn),
		.O_CLEANING(cln), .O_ROW_SHIFT(shf)
	);
	ets_trig_src src (.i_clk(clk), .o_trig(trig));

	// Verdict and end of run
	task summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// One APB transfer, held until ready is seen
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		r = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
		if (rdy !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
	endtask : xfer

	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask : rd

	// Disable, then enable with a new control word
	task automatic cfg(input logic [31:0] c);
		xfer(1'b1, ets_pkg::OFS_CTRL, 32'h0);
		xfer(1'b1, ets_pkg::OFS_CTRL, c);
		`WAITC(cln)
	endtask : cfg

	// Cycles the shutter stays open from now
	task automatic open_len;
		n = 0;
		while (shut === 1'b1 && n < 4000) begin
			@(posedge clk) #1;
			n++;
		end
	endtask : open_len

	// One readout: shutter level and row count
	task automatic frame(input logic s);
		`WAITC(!rdn)
		n = 0;
		while (rdn === 1'b0 && k < 4000) begin
			`CHK(shut, s)
			`CHK(sync, 1'b0)
			n += shf;
			@(posedge clk) #1;
			k++;
		end
		if (rdn !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		// Last row pulses just after readout ends
		n += shf;
		`CHK(n, 2)
	endtask : frame

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rd(ets_pkg::OFS_EXPOSURE, ets_pkg::EXPOSURE_RST);
		rd(ets_pkg::OFS_ROWS, 32'(ets_pkg::ROWS_RST));
		rd(ets_pkg::OFS_ROW_TIME, 32'(ets_pkg::ROW_TIME_RST));
		rd(8'h14, 32'h0);
		`CHK(e, 1'b1)
		xfer(1'b1, ets_pkg::OFS_STATUS, 32'hffff_ffff);
		rd(ets_pkg::OFS_STATUS, 32'h0);
		xfer(1'b1, ets_pkg::OFS_EXPOSURE, 32'h14);
		xfer(1'b1, ets_pkg::OFS_ROWS, 32'h2);
		xfer(1'b1, ets_pkg::OFS_ROW_TIME, 32'h3);
		rd(ets_pkg::OFS_EXPOSURE, 32'h14);
		$display("test registers done");
		cfg(32'h03);
		k = 0;
		n = 0;
		while (cln === 1'b1 && n < 100) begin
			k += shf;
			@(posedge clk) #1;
			n++;
		end
		// Last pass row pulses once cleaning has dropped
		k += shf;
		`CHK(k, 2)
		src.drive(1'b1, 1);
		repeat (10) @(posedge clk) #1;
		`CHK(shut, 1'b0)
		src.drive(1'b0, 1);
		src.drive(1'b1, 2);
		`WAITC(shut)
		`CHK(sync, 1'b1)
		open_len();
		`CHK(n, 20)
		frame(1'b0);
		$display("test trigger normal done");
		cfg(32'h6b);
		`WAITC(!cln)
		repeat (3) @(posedge clk) #1;
		`CHK(shut, 1'b1)
		src.drive(1'b0, 1);
		src.drive(1'b1, 2);
		src.drive(1'b0, 2);
		frame(1'b0);
		repeat (3) @(posedge clk) #1;
		`CHK(shut, 1'b1)
		$display("test trigger early done");
		cfg(32'h2d);
		repeat (30) @(posedge clk) #1;
		`CHK(cln, 1'b1)
		`CHK(shut, 1'b1)
		`WAITC(shf)
		// Edge lands mid-row so it is held pending
		src.drive(1'b1, 2);
		`WAITC(!cln)
		`CHK(k <= 8, 1'b1)
		src.drive(1'b0, 1);
		frame(1'b0);
		$display("test continuous clean done");
		cfg(32'h01);
		src.drive(1'b1, 1);
		src.drive(1'b0, 3);
		`WAITC(shut)
		open_len();
		`CHK(n, 20)
		frame(1'b0);
		`WAITC(shut)
		`CHK(k < 4, 1'b1)
		$display("test free run done");
		cfg(32'h7b);
		`WAITC(!cln)
		repeat (3) @(posedge clk) #1;
		`CHK(sync, 1'b1)
		src.drive(1'b1, 1);
		src.drive(1'b0, 2);
		repeat (8) @(posedge clk) #1;
		`CHK(shut, 1'b0)
		frame(1'b0);
		cfg(32'h73);
		`WAITC(!cln)
		src.drive(1'b1, 2);
		frame(1'b1);
		frame(1'b1);
		src.drive(1'b0, 1);
		$display("test disabled shutter done");
		summarize();
	end
endmodule : ets_sequencer_tb_top
